// file: hdl/lpsc_map.svh
// Constants for the link power state controller: timing, thresholds and codes.
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

`define LPSC_CLK_MHZ 50
`define LPSC_HPD_DB_MS 2
`define LPSC_HPD_DB_CYC ((`LPSC_HPD_DB_MS * `LPSC_CLK_MHZ * 1000))
`define LPSC_HPD_PROP_MAX_US 100
`define LPSC_STANDBY_ENTRY_MAX_US 300
`define LPSC_STANDBY_EXIT_MAX_US 200
`define LPSC_SIG_GLITCH_NS 25000
`define LPSC_SIG_DB_CYC (((`LPSC_SIG_GLITCH_NS * `LPSC_CLK_MHZ) + 999) / 1000 + 1)
`define LPSC_IDLE_GAP_NS 50
`define LPSC_IDLE_DB_CYC (((`LPSC_IDLE_GAP_NS * `LPSC_CLK_MHZ) + 999) / 1000 + 1)

`define LPSC_TERM_OPEN_MAX_MHZ 165
`define LPSC_TERM_300_MIN_MHZ 250
`define LPSC_LINK_CLK_DIV 64
`define LPSC_FREQ_WIN_CYC 1024
`define LPSC_OPEN_MAX_EDGES \
  ((`LPSC_TERM_OPEN_MAX_MHZ * `LPSC_FREQ_WIN_CYC + \
    `LPSC_LINK_CLK_DIV * `LPSC_CLK_MHZ - 1) / (`LPSC_LINK_CLK_DIV * `LPSC_CLK_MHZ))
`define LPSC_TERM300_MIN_EDGES \
  ((`LPSC_TERM_300_MIN_MHZ * `LPSC_FREQ_WIN_CYC) / (`LPSC_LINK_CLK_DIV * `LPSC_CLK_MHZ))

`define LPSC_TERM_AUTO_SEL 2'h0
`define LPSC_TERM_FIELD_AUTO 2'h2

`endif

// file: hdl/lpsc_pkg.sv
// Types shared by the link power state controller.
package lpsc_pkg;

  typedef enum logic [2:0] {
    LPSC_POWERDOWN = 3'b001,
    LPSC_STANDBY = 3'b010,
    LPSC_ACTIVE = 3'b100
  } lpsc_state_t;

  typedef enum logic [1:0] {
    LPSC_TERM_OPEN = 2'h0,
    LPSC_TERM_300 = 2'h1,
    LPSC_TERM_100 = 2'h2
  } lpsc_term_t;

endpackage : lpsc_pkg

// file: hdl/lpsc_debounce.sv
// Level debouncer that restarts its timer whenever the input changes.
module lpsc_debounce #(
  parameter int CNT_W = 17,
  parameter logic [CNT_W-1:0] DB_CYC = 17'd100000,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic level_in,
  output logic stable_out
);

  logic last;
  logic [CNT_W-1:0] count;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last <= RESET_LEVEL;
    end else begin
      last <= level_in;
    end
  end

  // The timer starts over on every edge of the input.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (level_in != last) begin
      count <= '0;
    end else if (count != DB_CYC) begin
      count <= count + 1'b1;
    end
  end

  // The new level is taken only once it has held for the whole interval.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stable_out <= RESET_LEVEL;
    end else if (level_in == last && count == DB_CYC - 1'b1) begin
      stable_out <= level_in;
    end
  end

endmodule : lpsc_debounce

// file: hdl/link_power_state_ctrl.sv
// Power state sequencer and automatic termination select for a video link redriver.
`include "lpsc_map.svh"

module link_power_state_ctrl #(
  parameter int HPD_DB_CYC = `LPSC_HPD_DB_CYC,
  parameter int SIG_DB_CYC = `LPSC_SIG_DB_CYC,
  parameter int IDLE_DB_CYC = `LPSC_IDLE_DB_CYC,
  parameter int FREQ_WIN_CYC = `LPSC_FREQ_WIN_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic por_done_in,
  input wire logic enable_in,
  input wire logic hot_plug_sense_in,
  input wire logic sig_detect_in,
  input wire logic link_clk_div_in,
  input wire logic legacy_rate_mode_in,
  input wire logic [1:0] legacy_rate_term_auto_in,
  input wire logic [1:0] term_field_in,
  input wire logic tx_dc_coupled_in,
  output logic hot_plug_sense_out,
  output lpsc_pkg::lpsc_state_t power_state_out,
  output logic powerdown_out,
  output logic standby_out,
  output logic active_out,
  output lpsc_pkg::lpsc_term_t tx_term_sel_out
);

  import lpsc_pkg::*;

  localparam int HPD_W = $clog2(HPD_DB_CYC + 1);
  localparam int SIG_W = $clog2(SIG_DB_CYC + 1);
  localparam int IDLE_W = $clog2(IDLE_DB_CYC + 1);
  localparam int WIN_W = $clog2(FREQ_WIN_CYC + 1);
  localparam logic [WIN_W-1:0] OPEN_MAX_EDGES = WIN_W'(`LPSC_OPEN_MAX_EDGES);
  localparam logic [WIN_W-1:0] TERM300_MIN_EDGES = WIN_W'(`LPSC_TERM300_MIN_EDGES);

  //////////////////////////////////////////////////////////////////////////////
  // Reset.

  logic int_rstn;

  // Logic is held in reset while power-on reset or enable is low.
  assign int_rstn = rstn_in & por_done_in & enable_in;

  //////////////////////////////////////////////////////////////////////////////
  // Debounce of hot-plug sense and of the signal detector.

  logic hpd_stable;
  logic sig_stable;
  logic idle_stable;
  logic sig_db_rstn;

  // Hot-plug sense must hold its new level for the whole interval.
  lpsc_debounce #(
    .CNT_W(HPD_W),
    .DB_CYC(HPD_W'(HPD_DB_CYC)),
    .RESET_LEVEL(1'b0)
  ) u_hpd_db (
    .sys_clk_in(sys_clk_in),
    .rstn_in(int_rstn),
    .level_in(hot_plug_sense_in),
    .stable_out(hpd_stable)
  );

  // The signal timer starts afresh after every spell of idle.
  assign sig_db_rstn = int_rstn & ~idle_stable;

  // Signal must persist beyond the longest rejected glitch.
  lpsc_debounce #(
    .CNT_W(SIG_W),
    .DB_CYC(SIG_W'(SIG_DB_CYC)),
    .RESET_LEVEL(1'b0)
  ) u_sig_db (
    .sys_clk_in(sys_clk_in),
    .rstn_in(sig_db_rstn),
    .level_in(sig_detect_in),
    .stable_out(sig_stable)
  );

  // Idle must persist beyond the longest ignored gap.
  lpsc_debounce #(
    .CNT_W(IDLE_W),
    .DB_CYC(IDLE_W'(IDLE_DB_CYC)),
    .RESET_LEVEL(1'b1)
  ) u_idle_db (
    .sys_clk_in(sys_clk_in),
    .rstn_in(int_rstn),
    .level_in(~sig_detect_in),
    .stable_out(idle_stable)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Hot-plug sense forwarding.

  // The output follows the input one clock later.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      hot_plug_sense_out <= 1'b0;
    end else begin
      hot_plug_sense_out <= hot_plug_sense_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state machine.

  lpsc_state_t state;
  lpsc_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      LPSC_POWERDOWN: begin
        if (hpd_stable) begin
          next_state = LPSC_STANDBY;
        end else begin
          next_state = LPSC_POWERDOWN;
        end
      end
      LPSC_STANDBY: begin
        if (!hpd_stable) begin
          next_state = LPSC_POWERDOWN;
        end else if (sig_stable && !idle_stable) begin
          next_state = LPSC_ACTIVE;
        end
      end
      LPSC_ACTIVE: begin
        if (!hpd_stable) begin
          next_state = LPSC_POWERDOWN;
        end else if (idle_stable) begin
          next_state = LPSC_STANDBY;
        end
      end
      default: begin
        next_state = LPSC_POWERDOWN;
      end
    endcase
  end

  // Powerdown leads only to standby, so active is reached through standby.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      state <= LPSC_POWERDOWN;
    end else begin
      state <= next_state;
    end
  end

  // The outputs take the next state, so they change on the same edge as the state.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      power_state_out <= LPSC_POWERDOWN;
    end else begin
      power_state_out <= next_state;
    end
  end

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      powerdown_out <= 1'b1;
    end else begin
      powerdown_out <= (next_state == LPSC_POWERDOWN);
    end
  end

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      standby_out <= 1'b0;
    end else begin
      standby_out <= (next_state == LPSC_STANDBY);
    end
  end

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      active_out <= 1'b0;
    end else begin
      active_out <= (next_state == LPSC_ACTIVE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link clock frequency measurement.

  logic clk_div_last;
  logic [WIN_W-1:0] win_count;
  logic [WIN_W-1:0] edge_count;
  logic win_done;
  logic div_rise;
  logic [WIN_W-1:0] edges_seen;
  logic meas_valid;

  assign win_done = (win_count == WIN_W'(FREQ_WIN_CYC - 1));
  assign div_rise = link_clk_div_in && !clk_div_last;

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      clk_div_last <= 1'b0;
    end else begin
      clk_div_last <= link_clk_div_in;
    end
  end

  // The window restarts whenever the link is powered down.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      win_count <= '0;
    end else if (win_done || state == LPSC_POWERDOWN) begin
      win_count <= '0;
    end else begin
      win_count <= win_count + 1'b1;
    end
  end

  // Rising edges of the divided link clock are counted over one window.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      edge_count <= '0;
    end else if (win_done || state == LPSC_POWERDOWN) begin
      edge_count <= '0;
    end else if (div_rise) begin
      edge_count <= edge_count + 1'b1;
    end
  end

  // An edge seen in the last sample of a window still counts for that window.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      edges_seen <= '0;
    end else if (state == LPSC_POWERDOWN) begin
      edges_seen <= '0;
    end else if (win_done) begin
      edges_seen <= edge_count + WIN_W'(div_rise);
    end
  end

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      meas_valid <= 1'b0;
    end else if (state == LPSC_POWERDOWN) begin
      meas_valid <= 1'b0;
    end else if (win_done) begin
      meas_valid <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit termination select.

  logic auto_term;
  logic slow_link;
  logic fast_link;
  lpsc_term_t auto_choice;
  lpsc_term_t auto_last;
  lpsc_term_t next_term;

  assign auto_term = legacy_rate_mode_in && tx_dc_coupled_in &&
                     legacy_rate_term_auto_in == `LPSC_TERM_AUTO_SEL &&
                     term_field_in == `LPSC_TERM_FIELD_AUTO;

  // A link clock is slow up to the open limit and fast from the 300 ohm limit.
  assign slow_link = !meas_valid || edges_seen <= OPEN_MAX_EDGES;
  assign fast_link = meas_valid && edges_seen >= TERM300_MIN_EDGES;

  // Between the two thresholds the previous choice is kept.
  always_comb begin
    auto_choice = auto_last;
    if (slow_link) begin
      auto_choice = LPSC_TERM_OPEN;
    end else if (fast_link) begin
      auto_choice = LPSC_TERM_300;
    end
  end

  // The kept choice is never a fixed setting left over from manual use.
  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      auto_last <= LPSC_TERM_OPEN;
    end else begin
      auto_last <= auto_choice;
    end
  end

  // Fixed settings apply unless every automatic condition holds.
  always_comb begin
    next_term = LPSC_TERM_OPEN;
    if (auto_term) begin
      next_term = auto_choice;
    end else if (term_field_in == 2'h1) begin
      next_term = LPSC_TERM_300;
    end else if (term_field_in == 2'h3) begin
      next_term = LPSC_TERM_100;
    end
  end

  always_ff @(posedge sys_clk_in or negedge int_rstn) begin
    if (!int_rstn) begin
      tx_term_sel_out <= LPSC_TERM_OPEN;
    end else begin
      tx_term_sel_out <= next_term;
    end
  end

endmodule : link_power_state_ctrl

// file: testbench/lpsc_properties.sv
// Port checker for the link power state controller.
module lpsc_properties #(
  parameter int HPD_DB_CYC = 50
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic por_done_in,
  input wire logic enable_in,
  input wire logic hot_plug_sense_in,
  input wire logic sig_detect_in,
  input wire logic hot_plug_sense_out,
  input wire lpsc_pkg::lpsc_state_t power_state_out,
  input wire logic powerdown_out,
  input wire logic standby_out,
  input wire logic active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpsc_pkg::*;
  wire rint = rstn_in & por_done_in & enable_in;
  int hlo;
  int hhi;
  ////////////////////////////////
  // Counts how long the hot-plug input has held its level.
  always_ff @(posedge sys_clk_in or negedge rint) begin
    if (!rint) begin
      hlo <= 0;
      hhi <= 0;
    end else begin
      hlo <= hot_plug_sense_in ? 0 : hlo + 1;
      hhi <= hot_plug_sense_in ? hhi + 1 : 0;
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rint);
  AST_RST_GATE: assert property (disable iff (!rstn_in)
    !por_done_in || !enable_in |-> power_state_out == LPSC_POWERDOWN && !hot_plug_sense_out)
    else $error("state not reset");
  AST_HPD_COPY: assert property ($past(rint) |-> hot_plug_sense_out == $past(hot_plug_sense_in))
    else $error("hot-plug copy wrong");
  AST_PD_ENTRY: assert property (hlo == HPD_DB_CYC + 5 |-> powerdown_out)
    else $error("powerdown late");
  AST_PD_EXIT: assert property (hhi == HPD_DB_CYC + 5 |-> !powerdown_out)
    else $error("powerdown exit late");
  AST_PD_EARLY: assert property ($rose(powerdown_out) |-> hlo >= HPD_DB_CYC)
    else $error("powerdown early");
  AST_EXIT_EARLY: assert property ($fell(powerdown_out) |-> hhi >= HPD_DB_CYC)
    else $error("powerdown exit early");
  AST_VIA_STBY: assert property ($rose(active_out) |-> $past(standby_out))
    else $error("active without standby");
  AST_IDLE_STBY: assert property ((!sig_detect_in && hot_plug_sense_in) [*8] |-> !active_out)
    else $error("idle not left active");
  AST_GAP_HOLD: assert property (active_out && hhi > 8 && $fell(sig_detect_in) ##1
    sig_detect_in |=> active_out)
    else $error("gap left active");
endmodule : lpsc_properties

bind link_power_state_ctrl lpsc_properties #(.HPD_DB_CYC(HPD_DB_CYC)) u_lpsc_properties (
  .sys_clk_in, .rstn_in, .por_done_in, .enable_in, .hot_plug_sense_in, .sig_detect_in,
  .hot_plug_sense_out, .power_state_out, .powerdown_out, .standby_out, .active_out
);

// file: testbench/lpsc_link_model.sv
// Source and sink model driving the link side inputs of the controller.
module lpsc_link_model (
  input wire logic sys_clk_in,
  input wire logic plug_in,
  input wire logic tx_on_in,
  input wire logic [7:0] half_in,
  output logic hot_plug_sense_out,
  output logic sig_detect_out,
  output logic link_clk_div_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    hot_plug_sense_out = 1'h0;
    sig_detect_out = 1'h0;
    link_clk_div_out = 1'h0;
  end
  // The divided link clock stands still while the source is silent.
  always @(posedge sys_clk_in) begin
    #1;
    hot_plug_sense_out = plug_in;
    sig_detect_out = tx_on_in;
    cnt = (cnt + 1 >= int'(half_in)) ? 0 : cnt + 1;
    if (!tx_on_in) begin
      link_clk_div_out = 1'h0;
    end else if (cnt == 0) begin
      link_clk_div_out = !link_clk_div_out;
    end
  end
endmodule : lpsc_link_model

// file: testbench/tb_top.sv
// Self-checking bench for the link power state controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpsc_pkg::*;
  localparam int HPD = 50;
  localparam int SIG = 1251;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic por = 1'h1;
  logic en = 1'h1;
  logic plug = 1'h0;
  logic tx = 1'h0;
  logic [7:0] half = 8'h0a;
  logic hpi, sig, lck, hpo, pd, sb, ac;
  lpsc_state_t pst;
  lpsc_term_t term;
  int fail_count = 0;
  int n_tests = 0;
  initial begin
    forever #10 clk = !clk;
  end
  link_power_state_ctrl #(.HPD_DB_CYC(HPD)) u_link_power_state_ctrl (
    .sys_clk_in(clk), .rstn_in(rstn), .por_done_in(por), .enable_in(en),
    .hot_plug_sense_in(hpi), .sig_detect_in(sig), .link_clk_div_in(lck),
    .legacy_rate_mode_in(1'h1), .legacy_rate_term_auto_in(2'h0), .term_field_in(2'h2),
    .tx_dc_coupled_in(1'h1), .hot_plug_sense_out(hpo), .power_state_out(pst),
    .powerdown_out(pd), .standby_out(sb), .active_out(ac), .tx_term_sel_out(term));
  lpsc_link_model u_lpsc_link_model (.sys_clk_in(clk), .plug_in(plug), .tx_on_in(tx),
    .half_in(half), .hot_plug_sense_out(hpi), .sig_detect_out(sig), .link_clk_div_out(lck));
  ////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_st(input lpsc_state_t st, input int lim);
    for (int i = 0; i < lim && pst !== st; i++) wt(1);
    chk(pst, st);
  endtask : wait_st
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////
  task automatic t_plug();
    plug = 1'h1;
    wt(HPD - 10);
    plug = 1'h0;
    wt(HPD + 20);
    chk(pst, LPSC_POWERDOWN);
    plug = 1'h1;
    wt(3);
    chk(hpo, 1'h1);
    wt(HPD - 10);
    chk(pst, LPSC_POWERDOWN);
    wait_st(LPSC_STANDBY, 20);
  endtask : t_plug
  task automatic t_sig();
    tx = 1'h1;
    wt(SIG - 11);
    tx = 1'h0;
    wt(SIG + 50);
    chk(pst, LPSC_STANDBY);
    tx = 1'h1;
    wt(SIG - 10);
    chk(pst, LPSC_STANDBY);
    wait_st(LPSC_ACTIVE, 30);
  endtask : t_sig
  task automatic t_idle();
    for (int g = 1; g < 3; g++) begin
      tx = 1'h0;
      wt(g);
      tx = 1'h1;
      wt(10);
      chk(pst, LPSC_ACTIVE);
    end
    tx = 1'h0;
    wait_st(LPSC_STANDBY, 15);
  endtask : t_idle
  task automatic t_term();
    tx = 1'h1;
    wait_st(LPSC_ACTIVE, SIG + 10);
    wt(3072);
    chk(term, LPSC_TERM_OPEN);
    half = 8'h06;
    wt(3072);
    chk(term, LPSC_TERM_300);
  endtask : t_term
  task automatic t_unplug();
    plug = 1'h0;
    wt(3);
    chk(hpo, 1'h0);
    wt(HPD - 10);
    chk(pst, LPSC_ACTIVE);
    wait_st(LPSC_POWERDOWN, 20);
    wt(SIG + 10);
    chk(pst, LPSC_POWERDOWN);
  endtask : t_unplug
  task automatic t_gate();
    plug = 1'h1;
    wait_st(LPSC_ACTIVE, HPD + 20);
    en = 1'h0;
    wt(2);
    chk({hpo, pst}, {1'h0, LPSC_POWERDOWN});
    por = 1'h0;
    en = 1'h1;
    wt(2);
    chk({hpo, pst}, {1'h0, LPSC_POWERDOWN});
    por = 1'h1;
    wait_st(LPSC_STANDBY, HPD + 20);
    wait_st(LPSC_ACTIVE, SIG + 20);
  endtask : t_gate
  ////////////////////////////////
  initial begin
    wt(8);
    rstn = 1'h1;
    t_plug();
    t_sig();
    t_idle();
    t_term();
    t_unplug();
    t_gate();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : tb_top
